// *** shared/acq_sync_cfg.svh ***
`ifndef ACQ_SYNC_CFG_SVH
`define ACQ_SYNC_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_CFG       8'h04
`define OFS_SCAN      8'h08
`define OFS_AI_DIV    8'h0C
`define OFS_AO_DIV    8'h10
`define OFS_THRESH    8'h14
`define OFS_LIST_ADDR 8'h18
`define OFS_LIST_DATA 8'h1C
`define OFS_STATUS    8'h20
`define OFS_XFER      8'h24
`define OFS_FLUSHED   8'h28
`define OFS_AO_LEN    8'h2C
`define OFS_AO_DATA   8'h30
`define OFS_DOUT      8'h34
`define OFS_POST      8'h38

// ----------------------------------------
// control and status bit positions
// ----------------------------------------
`define CTRL_AI_LIST  0
`define CTRL_AO_LIST  1
`define CTRL_PRESTART 2
`define CTRL_START    3
`define CTRL_STOP     4
`define CTRL_FLUSH    5
`define CTRL_SWTRIG   6
`define STAT_OVR      8

// ----------------------------------------
// sizes, reset values and timing
// ----------------------------------------
`define LIST_DEPTH    1024
`define SEG_LEN       64
`define AO_DEPTH      16
`define FIFO_DEPTH    8
`define DIO_CHAN      6'd32
`define DIV_RESET     16'h0063
`define CLK_PERIOD_NS 10
`define REARM_NS      2000
`define REARM_CYC     ((`REARM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** shared/acq_pkg.sv ***
package acq_pkg;

  typedef enum logic [1:0] {TRIG_SW, TRIG_EXT, TRIG_ANA, TRIG_CHAN} trig_src_t;
  typedef enum logic [1:0] {AI_CONT, AI_PRE, AI_PREPOST, AI_SCAN} ai_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_WAIT, ST_RUN} seq_state_t;

  // configuration word, low bits first from the right
  typedef struct packed {
    logic       diff;
    logic [4:0] trig_chan;
    logic       ao_wrap;
    ai_mode_t   ai_mode;
    logic       ao_single;
    logic       ai_single;
    logic       clk_ext;
    trig_src_t  trig_src;
  } cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// *** hdl/acq_sync_triggered_scan.sv ***
`timescale 1ns/1ps
`include "acq_sync_cfg.svh"

module sample_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_out  = (cnt_q != (AW+1)'(D));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rp_q];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module acq_sync_triggered_scan
  import acq_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // register port
  input  wire acq_pkg::reg_req_t reg_in,
  output logic [31:0]           reg_rdata_out,
  // input converter
  input  wire logic [15:0]      adc_data_in,
  output logic [5:0]            adc_chan_out,
  output logic                  adc_convert_out,
  // output converter and threshold level
  output logic [15:0]           dac_data_out,
  output logic                  dac_update_out,
  output logic [15:0]           thresh_dac_out,
  // trigger and clock pins
  input  wire logic             ext_trig_in,
  input  wire logic             ana_trig_in,
  input  wire logic             ext_clk_in,
  // shared digital lines
  input  wire logic [15:0]      shared_digital_lines_in,
  output logic [15:0]           shared_digital_lines_out,
  output logic [15:0]           shared_digital_lines_oe_out,
  // segment stream to host
  output logic [15:0]           seg_data_out,
  output logic                  seg_valid_out,
  output logic                  seg_last_out,
  input  wire logic             seg_ready_in
);
  import acq_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  seq_state_t  state_q;
  cfg_t        cfg_q;
  logic [1:0]  list_on_q;
  logic [9:0]  list_last_q;
  logic [7:0]  scans_last_q;
  logic [15:0] ai_div_q;
  logic [15:0] ao_div_q;
  logic [15:0] thresh_q;
  logic [9:0]  list_addr_q;
  logic [5:0]  channel_gain_list [`LIST_DEPTH];
  logic [15:0] ao_mem_q [`AO_DEPTH];
  logic [3:0]  ao_last_q;
  logic [3:0]  ao_wp_q;
  logic [15:0] post_q;
  logic [31:0] xfer_q;
  logic [31:0] flushed_q;
  logic        ovr_q;

  logic wr;
  logic ctl_wr;
  logic prestart;
  logic start;
  logic stop;
  logic flush;
  logic swtrig;
  logic sync_ok;

  assign wr       = reg_in.wr;
  assign ctl_wr   = wr && (reg_in.addr == `OFS_CTRL);
  assign prestart = ctl_wr && reg_in.wdata[`CTRL_PRESTART];
  assign start    = ctl_wr && reg_in.wdata[`CTRL_START];
  assign stop     = ctl_wr && reg_in.wdata[`CTRL_STOP];
  assign flush    = ctl_wr && reg_in.wdata[`CTRL_FLUSH];
  assign swtrig   = ctl_wr && reg_in.wdata[`CTRL_SWTRIG];
  assign sync_ok  = !cfg_q.ai_single && !cfg_q.ao_single;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q        <= '0;
      list_on_q    <= '0;
      list_last_q  <= '0;
      scans_last_q <= '0;
      ai_div_q     <= `DIV_RESET;
      ao_div_q     <= `DIV_RESET;
      thresh_q     <= '0;
      list_addr_q  <= '0;
      ao_last_q    <= '0;
      post_q       <= '0;
      shared_digital_lines_out    <= '0;
      shared_digital_lines_oe_out <= '0;
    end else if (wr) begin
      case (reg_in.addr)
        `OFS_CTRL:      list_on_q <= reg_in.wdata[1:0];
        `OFS_CFG:       cfg_q <= reg_in.wdata[$bits(cfg_t)-1:0];
        `OFS_SCAN: begin
          list_last_q  <= reg_in.wdata[9:0];
          scans_last_q <= reg_in.wdata[23:16];
        end
        `OFS_AI_DIV:    ai_div_q <= reg_in.wdata[15:0];
        `OFS_AO_DIV:    ao_div_q <= reg_in.wdata[15:0];
        `OFS_THRESH:    thresh_q <= reg_in.wdata[15:0];
        `OFS_LIST_ADDR: list_addr_q <= reg_in.wdata[9:0];
        `OFS_LIST_DATA: list_addr_q <= list_addr_q + 10'd1;
        `OFS_AO_LEN:    ao_last_q <= reg_in.wdata[3:0];
        `OFS_POST:      post_q <= reg_in.wdata[15:0];
        `OFS_DOUT: begin
          // one set of pins for both directions
          shared_digital_lines_out    <= reg_in.wdata[15:0];
          shared_digital_lines_oe_out <= reg_in.wdata[31:16];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr && reg_in.addr == `OFS_LIST_DATA) begin
      channel_gain_list[list_addr_q] <= reg_in.wdata[5:0];
    end
    if (wr && reg_in.addr == `OFS_AO_DATA) begin
      ao_mem_q[ao_wp_q] <= reg_in.wdata[15:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || (wr && reg_in.addr == `OFS_AO_LEN)) begin
      ao_wp_q <= '0;
    end else if (wr && reg_in.addr == `OFS_AO_DATA) begin
      ao_wp_q <= ao_wp_q + 4'd1;
    end
  end

  // threshold channel has no waveform path at all
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      thresh_dac_out <= '0;
    end else begin
      thresh_dac_out <= thresh_q;
    end
  end

  // ----------------------------------------
  // sample clocks
  // ----------------------------------------
  logic        ext_clk_q;
  logic        ext_trig_q;
  logic        ana_trig_q;
  logic [15:0] ai_cnt_q;
  logic [15:0] ao_cnt_q;
  logic        clk_run;
  logic        ext_edge;
  logic        ai_tick;
  logic        ao_tick;

  assign clk_run  = (state_q == ST_WAIT) || (state_q == ST_RUN);
  assign ext_edge = ext_clk_in && !ext_clk_q;
  // one external edge feeds both paths
  assign ai_tick  = clk_run && (cfg_q.clk_ext ? ext_edge : ai_cnt_q == '0);
  assign ao_tick  = clk_run && (cfg_q.clk_ext ? ext_edge : ao_cnt_q == '0);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_clk_q  <= 1'b0;
      ext_trig_q <= 1'b0;
      ana_trig_q <= 1'b0;
    end else begin
      ext_clk_q  <= ext_clk_in;
      ext_trig_q <= ext_trig_in;
      ana_trig_q <= ana_trig_in;
    end
  end

  // both dividers reload in the same cycle so equal rates stay aligned
  always_ff @(posedge clk_in) begin
    if (rst_in || !clk_run) begin
      ai_cnt_q <= ai_div_q;
      ao_cnt_q <= ao_div_q;
    end else begin
      ai_cnt_q <= (ai_cnt_q == '0) ? ai_div_q : ai_cnt_q - 16'd1;
      ao_cnt_q <= (ao_cnt_q == '0) ? ao_div_q : ao_cnt_q - 16'd1;
    end
  end

  // ----------------------------------------
  // trigger detection
  // ----------------------------------------
  logic       ai_run_q;
  logic       ao_run_q;
  logic       burst_q;
  logic [7:0] rearm_q;
  logic       monitor;
  logic       above_q;
  logic       above;
  logic       chan_evt;
  logic       trig_evt;
  logic       sampling;

  assign sampling = ai_run_q && (cfg_q.ai_mode != AI_SCAN || burst_q);
  assign monitor  = (cfg_q.trig_src == TRIG_CHAN) && clk_run && !sampling;
  assign above    = adc_data_in >= thresh_q;
  assign chan_evt = monitor && ai_tick && above && !above_q;

  always_ff @(posedge clk_in) begin
    if (rst_in || !monitor) begin
      above_q <= 1'b1;
    end else if (ai_tick) begin
      above_q <= above;
    end
  end

  always_comb begin
    case (cfg_q.trig_src)
      TRIG_SW:  trig_evt = swtrig;
      TRIG_EXT: trig_evt = ext_trig_in && !ext_trig_q;
      TRIG_ANA: trig_evt = ana_trig_in && !ana_trig_q;
      default:  trig_evt = chan_evt;
    endcase
  end

  // ----------------------------------------
  // start sequencer
  // ----------------------------------------
  logic go;
  logic early;
  logic burst_go;
  logic [9:0]  idx_q;
  logic [7:0]  scan_q;
  logic [15:0] post_cnt_q;
  logic        post_q_on;
  logic        push;
  logic        fifo_ready;

  // run-until-trigger modes begin acquiring at start
  assign early = cfg_q.ai_mode == AI_PRE || cfg_q.ai_mode == AI_PREPOST;
  assign go    = (state_q == ST_ARMED && start && (cfg_q.trig_src == TRIG_SW || early))
              || (state_q == ST_WAIT && trig_evt);
  // no queue: a trigger inside a burst or the re-arm gap is dropped
  assign burst_go = cfg_q.ai_mode == AI_SCAN && ai_run_q && !burst_q
                 && rearm_q == '0 && state_q == ST_RUN && trig_evt;
  assign push = sampling && ai_tick;

  always_ff @(posedge clk_in) begin
    if (rst_in || stop) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (prestart && sync_ok && list_on_q != '0) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (go) begin
            state_q <= ST_RUN;
          end else if (start) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (go) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!ai_run_q && !ao_run_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // input acquisition, list walk and scan bursts
  always_ff @(posedge clk_in) begin
    if (rst_in || stop) begin
      ai_run_q   <= 1'b0;
      burst_q    <= 1'b0;
      idx_q      <= '0;
      scan_q     <= '0;
      rearm_q    <= '0;
      post_cnt_q <= '0;
      post_q_on  <= 1'b0;
    end else begin
      if (rearm_q != '0) begin
        rearm_q <= rearm_q - 8'd1;
      end
      if (go) begin
        ai_run_q <= list_on_q[`CTRL_AI_LIST];
        burst_q  <= cfg_q.ai_mode == AI_SCAN;
        idx_q    <= '0;
        scan_q   <= '0;
      end else if (burst_go) begin
        burst_q <= 1'b1;
        idx_q   <= '0;
        scan_q  <= '0;
      end else if (push) begin
        if (idx_q == list_last_q) begin
          idx_q  <= '0;
          scan_q <= scan_q + 8'd1;
          if (burst_q && scan_q == scans_last_q) begin
            burst_q <= 1'b0;
            rearm_q <= 8'(`REARM_CYC);
          end
        end else begin
          idx_q <= idx_q + 10'd1;
        end
      end
      if (ai_run_q && state_q == ST_RUN && early && !post_q_on && trig_evt) begin
        if (cfg_q.ai_mode == AI_PRE) begin
          ai_run_q <= 1'b0;
        end else begin
          post_q_on  <= 1'b1;
          post_cnt_q <= post_q;
        end
      end else if (post_q_on && push) begin
        if (post_cnt_q == '0) begin
          ai_run_q  <= 1'b0;
          post_q_on <= 1'b0;
        end else begin
          post_cnt_q <= post_cnt_q - 16'd1;
        end
      end
    end
  end

  // converter channel select and convert strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_chan_out    <= '0;
      adc_convert_out <= 1'b0;
    end else begin
      adc_chan_out    <= monitor ? {1'b0, cfg_q.trig_chan} : channel_gain_list[idx_q];
      adc_convert_out <= ai_tick && (sampling || monitor);
    end
  end

  // ----------------------------------------
  // output waveform path
  // ----------------------------------------
  logic [3:0] ao_rp_q;

  always_ff @(posedge clk_in) begin
    if (rst_in || stop) begin
      ao_run_q       <= 1'b0;
      ao_rp_q        <= '0;
      dac_data_out   <= '0;
      dac_update_out <= 1'b0;
    end else begin
      dac_update_out <= 1'b0;
      if (go) begin
        ao_run_q <= list_on_q[`CTRL_AO_LIST];
        ao_rp_q  <= '0;
      end else if (ao_run_q && ao_tick) begin
        dac_data_out   <= ao_mem_q[ao_rp_q];
        dac_update_out <= 1'b1;
        if (ao_rp_q == ao_last_q) begin
          ao_rp_q <= '0;
          if (!cfg_q.ao_wrap) begin
            ao_run_q <= 1'b0;
          end
        end else begin
          ao_rp_q <= ao_rp_q + 4'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // sample buffer and segment delivery
  // ----------------------------------------
  logic [15:0] sample;
  logic [15:0] f_data;
  logic        f_valid;
  logic        f_pop;
  logic [15:0] seg_mem_q [`SEG_LEN];
  logic [5:0]  fill_q;
  logic [5:0]  rd_q;
  logic        send_q;

  assign sample = (adc_chan_out == `DIO_CHAN) ? shared_digital_lines_in : adc_data_in;
  assign f_pop  = f_valid && !send_q && !flush;

  sample_fifo #(
    .W (16),
    .D (`FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (sample),
    .out_valid_out (f_valid),
    .out_ready_in  (f_pop),
    .out_data_out  (f_data)
  );

  always_ff @(posedge clk_in) begin
    if (f_pop) begin
      seg_mem_q[fill_q] <= f_data;
    end
  end

  // a segment is only released once all 64 words are present
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fill_q        <= '0;
      rd_q          <= '0;
      send_q        <= 1'b0;
      seg_valid_out <= 1'b0;
      seg_last_out  <= 1'b0;
      seg_data_out  <= '0;
      xfer_q        <= '0;
      flushed_q     <= '0;
    end else begin
      if (flush && !send_q) begin
        fill_q    <= '0;
        flushed_q <= '0;
      end else if (f_pop) begin
        fill_q <= fill_q + 6'd1;
        if (fill_q == 6'(`SEG_LEN - 1)) begin
          send_q <= 1'b1;
        end
      end
      if (seg_valid_out && seg_ready_in) begin
        seg_valid_out <= 1'b0;
        if (seg_last_out) begin
          xfer_q <= xfer_q + 32'(`SEG_LEN);
        end
      end
      if (send_q && (!seg_valid_out || seg_ready_in)) begin
        seg_data_out  <= seg_mem_q[rd_q];
        seg_valid_out <= 1'b1;
        seg_last_out  <= rd_q == 6'(`SEG_LEN - 1);
        rd_q          <= rd_q + 6'd1;
        if (rd_q == 6'(`SEG_LEN - 1)) begin
          send_q <= 1'b0;
        end
      end
    end
  end

  // overrun: a new loss wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ovr_q <= 1'b0;
    end else if (push && !fifo_ready) begin
      ovr_q <= 1'b1;
    end else if (wr && reg_in.addr == `OFS_STATUS && reg_in.wdata[`STAT_OVR]) begin
      ovr_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // read-back
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_in.rd) begin
      case (reg_in.addr)
        `OFS_CTRL:      reg_rdata_out <= {30'h0, list_on_q};
        `OFS_CFG:       reg_rdata_out <= 32'(cfg_q);
        `OFS_SCAN:      reg_rdata_out <= {8'h00, scans_last_q, 6'h00, list_last_q};
        `OFS_AI_DIV:    reg_rdata_out <= {16'h0000, ai_div_q};
        `OFS_AO_DIV:    reg_rdata_out <= {16'h0000, ao_div_q};
        `OFS_THRESH:    reg_rdata_out <= {16'h0000, thresh_q};
        `OFS_LIST_ADDR: reg_rdata_out <= {22'h0, list_addr_q};
        `OFS_LIST_DATA: reg_rdata_out <= {26'h0, channel_gain_list[list_addr_q]};
        `OFS_STATUS:    reg_rdata_out <= {23'h0, ovr_q, send_q, sync_ok, burst_q,
                                          ao_run_q, ai_run_q, 1'b0, state_q};
        `OFS_XFER:      reg_rdata_out <= xfer_q;
        `OFS_FLUSHED:   reg_rdata_out <= flushed_q;
        `OFS_AO_LEN:    reg_rdata_out <= {28'h0, ao_last_q};
        `OFS_DOUT:      reg_rdata_out <= {shared_digital_lines_oe_out,
                                          shared_digital_lines_in};
        `OFS_POST:      reg_rdata_out <= {16'h0000, post_q};
        default:        reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// *** sim/host_seg_sink.sv ***
`timescale 1ns/1ps
module host_seg_sink (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // stream control
  input  wire logic stall_in,
  output logic      seg_ready_out
);
  logic phase_q;

  // host is ready every other cycle so backpressure shows even when not stalled
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q       <= 1'b0;
      seg_ready_out <= 1'b0;
    end else begin
      phase_q       <= !phase_q;
      seg_ready_out <= !stall_in && phase_q;
    end
  end
endmodule

// *** sim/acq_scan_sva.sv ***
`timescale 1ns/1ps
`include "acq_sync_cfg.svh"
module acq_scan_sva (
  // clock and reset
  input wire logic              clk_in,
  input wire logic              rst_in,
  // register port
  input wire acq_pkg::reg_req_t reg_in,
  input wire logic [31:0]       reg_rdata_out,
  // watched outputs
  input wire logic [15:0]       thresh_dac_out,
  input wire logic [15:0]       shared_digital_lines_out,
  input wire logic [15:0]       shared_digital_lines_oe_out,
  input wire logic [15:0]       seg_data_out,
  input wire logic              seg_valid_out,
  input wire logic              seg_last_out,
  input wire logic              seg_ready_in
);
  logic [5:0]  hs_q;
  logic [31:0] thr_q;
  logic [31:0] dout_q;
  logic [1:0]  thr_age_q;
  logic [1:0]  dout_age_q;
  wire         hs      = seg_valid_out && seg_ready_in;
  wire         thr_wr  = reg_in.wr && reg_in.addr == `OFS_THRESH;
  wire         dout_wr = reg_in.wr && reg_in.addr == `OFS_DOUT;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ----
  // shadows
  // ----
  always_ff @(posedge clk_in) begin
    if (rst_in) hs_q <= 6'h00;
    else if (hs) hs_q <= hs_q + 6'h01;
  end
  // ages saturate at 3: outputs are only judged once a write has settled
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      thr_q     <= 32'h0;
      thr_age_q <= 2'h3;
    end else if (thr_wr) begin
      thr_q     <= reg_in.wdata;
      thr_age_q <= 2'h0;
    end else if (thr_age_q != 2'h3) thr_age_q <= thr_age_q + 2'h1;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dout_q     <= 32'h0;
      dout_age_q <= 2'h3;
    end else if (dout_wr) begin
      dout_q     <= reg_in.wdata;
      dout_age_q <= 2'h0;
    end else if (dout_age_q != 2'h3) dout_age_q <= dout_age_q + 2'h1;
  end

  // ----
  // properties
  // ----
  property p_seg_hold;
    seg_valid_out && !seg_ready_in |=>
      seg_valid_out && $stable(seg_data_out) && $stable(seg_last_out);
  endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("stream word dropped");
  property p_seg_last;
    hs |-> seg_last_out == (hs_q == 6'h3F);
  endproperty
  a_seg_last: assert property (p_seg_last) else $error("segment end misplaced");
  property p_xfer;
    reg_in.rd && reg_in.addr == `OFS_XFER |=> reg_rdata_out[5:0] == 6'h00;
  endproperty
  a_xfer: assert property (p_xfer) else $error("partial segment counted");
  property p_flushed;
    reg_in.rd && reg_in.addr == `OFS_FLUSHED |=> reg_rdata_out == 32'h0;
  endproperty
  a_flushed: assert property (p_flushed) else $error("flush count not zero");
  property p_thresh;
    thr_age_q >= 2'h2 |-> thresh_dac_out == thr_q[15:0];
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold level wrong");
  property p_dout;
    dout_age_q >= 2'h2 |-> shared_digital_lines_out == dout_q[15:0];
  endproperty
  a_dout: assert property (p_dout) else $error("digital out wrong");
  property p_dout_oe;
    dout_age_q >= 2'h2 |-> shared_digital_lines_oe_out == dout_q[31:16];
  endproperty
  a_dout_oe: assert property (p_dout_oe) else $error("digital enable wrong");
  property p_dout_read;
    reg_in.rd && reg_in.addr == `OFS_DOUT && dout_age_q == 2'h3 |=>
      reg_rdata_out[31:16] == dout_q[31:16];
  endproperty
  a_dout_read: assert property (p_dout_read) else $error("enable readback wrong");
endmodule

bind acq_sync_triggered_scan acq_scan_sva acq_scan_sva_inst (
  .clk_in(clk_in), .rst_in(rst_in), .reg_in(reg_in), .reg_rdata_out(reg_rdata_out),
  .thresh_dac_out(thresh_dac_out), .shared_digital_lines_out(shared_digital_lines_out),
  .shared_digital_lines_oe_out(shared_digital_lines_oe_out), .seg_data_out(seg_data_out),
  .seg_valid_out(seg_valid_out), .seg_last_out(seg_last_out), .seg_ready_in(seg_ready_in)
);

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "acq_sync_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  import acq_pkg::*;
  logic        clk_in;
  logic        rst_in;
  logic        ext_trig_in;
  logic        stall;
  logic        conv;
  logic        ext_clk;
  logic        seg_ready_in;
  logic        seg_valid_out;
  logic        seg_last_out;
  reg_req_t    reg_in;
  logic [31:0] reg_rdata_out;
  logic [31:0] rdata;
  logic [15:0] adc_data_in;
  logic [15:0] thresh_dac_out;
  logic [15:0] dio_out;
  logic [15:0] dio_oe;
  logic [15:0] seg_data_out;
  logic [5:0]  adc_chan_out;
  int          errors;
  int          n_tests;
  int          wcnt;
  int          nconv;
  int          c0;
  logic [39:0] rows [7] = '{{`OFS_STATUS, 32'h40}, {`OFS_AI_DIV, 32'h63},
    {`OFS_AO_DIV, 32'h63}, {`OFS_XFER, 32'h0}, {`OFS_FLUSHED, 32'h0},
    {8'h3C, 32'h0}, {`OFS_DOUT, 32'h5A3C}};

  acq_sync_triggered_scan acq_sync_triggered_scan_inst (
    .clk_in(clk_in), .rst_in(rst_in), .reg_in(reg_in), .reg_rdata_out(reg_rdata_out),
    .adc_data_in(adc_data_in), .adc_chan_out(adc_chan_out), .adc_convert_out(conv),
    .dac_data_out(), .dac_update_out(), .thresh_dac_out(thresh_dac_out),
    .ext_trig_in(ext_trig_in), .ana_trig_in(1'b0), .ext_clk_in(ext_clk),
    .shared_digital_lines_in(16'h5A3C), .shared_digital_lines_out(dio_out),
    .shared_digital_lines_oe_out(dio_oe), .seg_data_out(seg_data_out),
    .seg_valid_out(seg_valid_out), .seg_last_out(seg_last_out),
    .seg_ready_in(seg_ready_in));
  host_seg_sink host_seg_sink_inst (
    .clk_in(clk_in), .rst_in(rst_in), .stall_in(stall), .seg_ready_out(seg_ready_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) adc_data_in <= {10'h000, adc_chan_out};
  // free-running external sample clock at half the system rate
  always @(posedge clk_in) ext_clk <= rst_in ? 1'b0 : ~ext_clk;
  always @(posedge clk_in) if (conv === 1'b1) nconv++;
  always @(posedge clk_in) begin
    if (seg_valid_out && seg_ready_in) begin
      `CHK(seg_data_out, 16'h5A3C)
      `CHK(seg_last_out, wcnt % 64 == 63)
      wcnt++;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_in <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    reg_in <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_in <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_in);
    reg_in <= '0;
    #1 rdata = reg_rdata_out;
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    rst_in = 1'b1;
    reg_in = '0;
    ext_trig_in = 1'b0;
    stall = 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i][39:32]);
      `CHK(rdata, rows[i][31:0])
    end
    wr(`OFS_CFG, 32'h8);
    wr(`OFS_CTRL, 32'h5);
    rd(`OFS_STATUS);
    `CHK(rdata[1:0], 2'h0)
    wr(`OFS_CFG, 32'h80);
    wr(`OFS_CTRL, 32'hB);
    rd(`OFS_STATUS);
    `CHK(rdata[1:0], 2'h0)
    wr(`OFS_AI_DIV, 32'h1);
    wr(`OFS_AO_DIV, 32'h1);
    wr(`OFS_SCAN, 32'h0);
    wr(`OFS_LIST_ADDR, 32'h0);
    wr(`OFS_LIST_DATA, 32'h20);
    wr(`OFS_CTRL, 32'h7);
    rd(`OFS_STATUS);
    `CHK(rdata[1:0], 2'h1)
    wr(`OFS_CTRL, 32'hB);
    rd(`OFS_STATUS);
    `CHK(rdata & 32'h1B, 32'h1B)
    // host stalls first so the sample buffer fills up
    repeat (300) @(posedge clk_in);
    stall <= 1'b0;
    for (int k = 0; k < 40000 && wcnt < 64; k++) @(posedge clk_in);
    if (wcnt < 64) begin
      errors++;
      finish_test();
    end
    wr(`OFS_CTRL, 32'h13);
    rd(`OFS_XFER);
    `CHK(rdata[5:0], 6'h00)
    rd(`OFS_STATUS);
    `CHK(rdata[8], 1'b1)
    wr(`OFS_CTRL, 32'h23);
    rd(`OFS_FLUSHED);
    `CHK(rdata, 32'h0)
    wr(`OFS_CFG, 32'h81);
    wr(`OFS_CTRL, 32'h7);
    wr(`OFS_CTRL, 32'hB);
    rd(`OFS_STATUS);
    `CHK(rdata[1:0], 2'h2)
    ext_trig_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    ext_trig_in <= 1'b0;
    rd(`OFS_STATUS);
    `CHK(rdata[1:0], 2'h3)
    wr(`OFS_CTRL, 32'h13);
    wr(`OFS_THRESH, 32'h8001);
    repeat (3) @(posedge clk_in);
    `CHK(thresh_dac_out, 16'h8001)
    wr(`OFS_DOUT, 32'hFFFF00A5);
    repeat (3) @(posedge clk_in);
    `CHK({dio_oe, dio_out}, 32'hFFFF00A5)
    rd(`OFS_DOUT);
    `CHK(rdata, 32'hFFFF5A3C)
    // scan bursts paced by the external clock; the slow divider would give no samples
    wr(`OFS_AI_DIV, 32'hFFFF);
    wr(`OFS_CFG, 32'h65);
    wr(`OFS_SCAN, 32'h10001);
    wr(`OFS_LIST_DATA, 32'h20);
    wr(`OFS_CTRL, 32'h7);
    wr(`OFS_CTRL, 32'hB);
    c0 = nconv;
    for (int t = 0; t < 3; t++) begin
      ext_trig_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      ext_trig_in <= 1'b0;
      repeat (t == 1 ? 250 : 30) @(posedge clk_in);
      if (t == 0) `CHK(nconv - c0, 4)
    end
    `CHK(nconv - c0, 8)
    rd(`OFS_STATUS);
    `CHK(rdata[5:3], 3'h1)
    finish_test();
  end
endmodule
